// [hw/sfl_link.sv]
// Serial flash link: slave side of the serial bus plus operation timing.
// Assumes the link pins arrive asynchronously and the link clock runs far
// below the system clock, so its edges are found by oversampling.
`timescale 1ns/1ns
module sfl_link
    import sfl_pkg::*;
#(
    parameter int EP_CYCLES = EP_CYC,
    parameter int P_CYCLES = P_CYC,
    parameter int OTP_CYCLES = OTP_CYC,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic wp_n_in,
    output logic so_out,
    output logic so_oe_out,
    output logic busy_out,
    output logic protect_out,
    output logic lockdown_out,
    output logic dpd_out,
    output logic udpd_out,
    output logic overrun_out,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in
);
    // ==========================================================
    // Elaboration checks
    generate
        if (EP_CYCLES < 2 || EP_CYCLES >= 2**TMR_W || P_CYCLES < 2 || P_CYCLES >= 2**TMR_W
            || OTP_CYCLES < 2 || OTP_CYCLES >= 2**TMR_W) begin : g_bad
            $error("sfl_link: operation counts must lie in 2 .. 2**TMR_W-1");
        end
    endgenerate

    // ==========================================================
    // State
    typedef struct packed {
        logic sck1, sck2, sck3;
        logic cs1, cs2, cs3;
        logic si1, si2;
        logic wp1, wp2;
        logic [2:0] bit_cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] cmd;
        logic got_op;
        logic [7:0] op;
        sfl_mode_t mode;
        logic [TMR_W-1:0] timer;
        logic so, so_oe, busy, protect, lockdown, dpd, udpd, overrun;
    } sfl_link_st_t;

    sfl_link_st_t st;
    sfl_link_st_t next_st;
    logic rise, fall, cs_fall, cs_rise, launch;
    logic [7:0] status;
    logic [7:0] rx_byte;
    logic push;

    sfl_stream_if #(.W(8)) rx_if ();

    // Cycles that a mode lasts; the loaded timer is one less because the
    // edge detection on the pins already costs a cycle.
    function automatic logic [TMR_W-1:0] limit(input sfl_mode_t m, input logic [7:0] op);
        logic [TMR_W-1:0] r;
        r = TMR_W'(2);
        unique case (m)
            M_DPD_ENT: r = TMR_W'(EDPD_CYC);
            M_RESUME: r = TMR_W'(RDPD_CYC);
            M_UDPD_ENT: r = TMR_W'(EUDPD_CYC);
            M_WAKE: r = TMR_W'(XUDPD_CYC);
            M_BUSY: begin
                if (op == OP_XFR || op == OP_CMP) begin
                    r = TMR_W'(XFR_CYC);
                end else if (op == OP_EP) begin
                    r = TMR_W'(EP_CYCLES);
                end else if (op == OP_PROG) begin
                    r = TMR_W'(P_CYCLES);
                end else if (op == OP_OTP) begin
                    r = TMR_W'(OTP_CYCLES);
                end else if (op == OP_LOCK) begin
                    r = TMR_W'(LOCK_CYC);
                end
            end
            M_IDLE, M_DPD, M_UDPD: r = TMR_W'(2);
        endcase
        return r;
    endfunction

    // First flip-flops feed only the second; edges use the second and third.
    assign rise = st.sck2 && !st.sck3;
    assign fall = !st.sck2 && st.sck3;
    assign cs_fall = !st.cs2 && st.cs3;
    assign cs_rise = st.cs2 && !st.cs3;
    assign launch = cs_fall || (fall && !st.cs2);
    assign rx_byte = {st.sh[6:0], st.si2};

    always_comb begin
        status = ST_RESET;
        status[ST_BUSY] = st.busy;
        status[ST_PROT] = st.protect;
        status[ST_LOCK] = st.lockdown;
        status[ST_OVR] = st.overrun;
    end

    assign rx_if.data = rx_byte;
    assign rx_if.valid = push;

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_st = st;
        push = 1'b0;
        next_st.sck1 = sck_in;
        next_st.sck2 = st.sck1;
        next_st.sck3 = st.sck2;
        next_st.cs1 = cs_n_in;
        next_st.cs2 = st.cs1;
        next_st.cs3 = st.cs2;
        next_st.si1 = si_in;
        next_st.si2 = st.si1;
        next_st.wp1 = wp_n_in;
        next_st.wp2 = st.wp1;
        next_st.protect = !st.wp2;

        // Start of frame: first bit is put out before any clock edge
        if (cs_fall) begin
            next_st.bit_cnt = 3'h0;
            next_st.got_op = 1'b0;
            next_st.overrun = 1'b0;
            next_st.so_oe = (st.mode == M_IDLE || st.mode == M_BUSY);
            next_st.so = status[7];
            next_st.tx = {status[6:0], 1'b0};
        end
        if (rise && !st.cs2) begin
            next_st.sh = rx_byte;
            next_st.bit_cnt = 3'(st.bit_cnt + 3'h1);
            if (st.bit_cnt == 3'h7) begin
                if (!st.got_op) begin
                    next_st.cmd = rx_byte;
                    next_st.got_op = 1'b1;
                end
                push = (st.mode == M_IDLE || st.mode == M_BUSY);
                if (push && !rx_if.ready) begin
                    // Link cannot be stalled, so a full buffer loses the byte
                    next_st.overrun = 1'b1;
                end
            end
        end
        if (fall && !st.cs2) begin
            if (st.bit_cnt == 3'h0) begin
                next_st.so = status[7];
                next_st.tx = {status[6:0], 1'b0};
            end else begin
                next_st.so = st.tx[7];
                next_st.tx = {st.tx[6:0], 1'b0};
            end
        end

        // End of frame: a whole number of bytes starts the command
        if (cs_rise) begin
            next_st.so_oe = 1'b0;
            if (st.got_op && st.bit_cnt == 3'h0) begin
                if (st.mode == M_IDLE) begin
                    unique case (st.cmd)
                        OP_DPD: next_st.mode = M_DPD_ENT;
                        OP_UDPD: next_st.mode = M_UDPD_ENT;
                        OP_XFR, OP_CMP, OP_EP, OP_PROG, OP_OTP, OP_LOCK: begin
                            next_st.mode = M_BUSY;
                            next_st.op = st.cmd;
                        end
                        default: next_st.mode = M_IDLE;
                    endcase
                end else if (st.mode == M_DPD && st.cmd == OP_RESUME) begin
                    next_st.mode = M_RESUME;
                end
            end
        end

        // A sampled low chip select is taken as the wake pulse
        if (st.mode == M_UDPD && !st.cs2) begin
            next_st.mode = M_WAKE;
        end

        if (st.mode != M_IDLE && st.mode != M_DPD && st.mode != M_UDPD) begin
            if (st.timer <= TMR_W'(1)) begin
                unique case (st.mode)
                    M_DPD_ENT: next_st.mode = M_DPD;
                    M_UDPD_ENT: next_st.mode = M_UDPD;
                    M_RESUME, M_WAKE: next_st.mode = M_IDLE;
                    M_BUSY: begin
                        next_st.mode = M_IDLE;
                        if (st.op == OP_LOCK) begin
                            next_st.lockdown = 1'b1;
                        end
                    end
                    M_IDLE, M_DPD, M_UDPD: next_st.mode = st.mode;
                endcase
            end else begin
                next_st.timer = TMR_W'(st.timer - TMR_W'(1));
            end
        end
        if (next_st.mode != st.mode) begin
            next_st.timer = TMR_W'(limit(next_st.mode, next_st.op) - TMR_W'(1));
        end
        next_st.busy = (next_st.mode != M_IDLE);
        next_st.dpd = (next_st.mode == M_DPD);
        next_st.udpd = (next_st.mode == M_UDPD);
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '{sck1: 1'b0, sck2: 1'b0, sck3: 1'b0, cs1: 1'b1, cs2: 1'b1, cs3: 1'b1,
                    wp1: 1'b1, wp2: 1'b1, mode: M_IDLE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign so_out = st.so;
    assign so_oe_out = st.so_oe;
    assign busy_out = st.busy;
    assign protect_out = st.protect;
    assign lockdown_out = st.lockdown;
    assign dpd_out = st.dpd;
    assign udpd_out = st.udpd;
    assign overrun_out = st.overrun;

    // ==========================================================
    // Receive buffer
    sfl_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .wr(rx_if.snk),
        .rd_data_out(rx_data_out),
        .rd_valid_out(rx_valid_out),
        .rd_ready_in(rx_ready_in)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic [TMR_W:0] age;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            age <= '0;
        end else if (next_st.mode != st.mode) begin
            age <= '0;
        end else begin
            age <= (TMR_W+1)'(age + 1'b1);
        end
    end

    sequence s_cmd_end(logic [7:0] code);
        cs_rise && st.mode == M_IDLE && st.got_op && st.bit_cnt == 3'h0 && st.cmd == code;
    endsequence
    sequence s_resume_end;
        cs_rise && st.mode == M_DPD && st.got_op && st.bit_cnt == 3'h0 && st.cmd == OP_RESUME;
    endsequence
    sequence s_lock_end;
        st.mode == M_BUSY && st.op == OP_LOCK && st.timer <= TMR_W'(1);
    endsequence

    chk_wp_enable: assert property ($fell(st.wp2) |=> protect_out)
        else $error("protection not enabled after write-protect low");
    chk_wp_disable: assert property ($rose(st.wp2) |=> !protect_out)
        else $error("protection not released after write-protect high");
    chk_lock_freeze: assert property (s_lock_end |=> lockdown_out && !busy_out)
        else $error("lockdown not frozen at end of its operation");
    chk_udpd_entry: assert property (s_cmd_end(OP_UDPD) |-> ##[1:80] udpd_out)
        else $error("ultra-deep power-down entered late");
    chk_udpd_wake: assert property (st.mode == M_UDPD && !st.cs2 |=> st.mode == M_WAKE)
        else $error("low chip select did not start wake-up");
    chk_dpd_entry: assert property (s_cmd_end(OP_DPD) |-> ##[1:40] dpd_out)
        else $error("deep power-down entered late");
    chk_dpd_resume: assert property (s_resume_end |-> ##[1:700] !busy_out)
        else $error("resume from deep power-down took too long");
    chk_op_bound: assert property ((st.mode != M_IDLE && st.mode != M_DPD
        && st.mode != M_UDPD) |-> age < ({1'b0, limit(st.mode, st.op)} - 1'b1))
        else $error("timed operation ran past its longest duration");
    chk_so_launch: assert property ($changed(so_out) |-> $past(launch))
        else $error("data output changed away from a falling link clock edge");
    chk_si_sample: assert property (rise && !st.cs2 |=>
        st.bit_cnt == 3'($past(st.bit_cnt) + 3'h1))
        else $error("input bit not counted on rising link clock edge");
    chk_out_early: assert property (cs_fall && st.mode == M_IDLE |=>
        so_oe_out && so_out == $past(status[7]))
        else $error("first output bit not driven at chip select fall");
endmodule

// [hw/sfl_pkg.sv]
// Constants, field layout and state codes of the serial flash link block.
// Assumes a 20 MHz system clock; every timing count below is derived from it.
//
// Functional notes
// - Protection turns on within 1 us of write-protect going low and off within 1 us of it rising.
// - Lockdown freeze completes within 100 us of chip select rising after its command.
// - Ultra-deep power-down is reached within 4 us of chip select rising after its command.
// - A chip select low of 20 ns wakes ultra-deep power-down (the code wakes only on a low sampled at a clock edge); the device is ready within 180 us.
// - Deep power-down is entered within 2 us and left within 35 us of the resume command.
// - Page-to-buffer transfer and compare each finish within 200 us.
// - Page erase-and-program finishes within 35 ms (17 ms typical).
// - Page program without erase finishes within 5.5 ms (3 ms typical).
// - Security register programming finishes within 500 us (200 us typical).
// - Output bits launch on falling link clock edges; input bits are sampled on rising ones.
// - In mode 0 and 3 timing the first output bit is valid while the link clock is still low.
package sfl_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int US_CYC = CLK_HZ / 1_000_000;
    localparam int T_WP_US = 1;
    localparam int T_LOCK_US = 100;
    localparam int T_EUDPD_US = 4;
    localparam int T_XUDPD_US = 180;
    localparam int T_EDPD_US = 2;
    localparam int T_RDPD_US = 35;
    localparam int T_XFR_US = 200;
    localparam int T_EP_MS = 35;
    localparam real T_P_MS = 5.5;
    localparam int T_OTP_US = 500;
    localparam int WP_CYC = T_WP_US * US_CYC;
    localparam int LOCK_CYC = T_LOCK_US * US_CYC;
    localparam int EUDPD_CYC = T_EUDPD_US * US_CYC;
    localparam int XUDPD_CYC = T_XUDPD_US * US_CYC;
    localparam int EDPD_CYC = T_EDPD_US * US_CYC;
    localparam int RDPD_CYC = T_RDPD_US * US_CYC;
    localparam int XFR_CYC = T_XFR_US * US_CYC;
    localparam int EP_CYC = T_EP_MS * 1000 * US_CYC;
    localparam int P_CYC = int'($floor(T_P_MS * 1000.0)) * US_CYC;
    localparam int OTP_CYC = T_OTP_US * US_CYC;
    localparam int TMR_W = 20;

    // ==========================================================
    // Command codes
    localparam logic [7:0] OP_XFR = 8'h53;
    localparam logic [7:0] OP_CMP = 8'h60;
    localparam logic [7:0] OP_EP = 8'h83;
    localparam logic [7:0] OP_PROG = 8'h88;
    localparam logic [7:0] OP_OTP = 8'h9B;
    localparam logic [7:0] OP_LOCK = 8'h7F;
    localparam logic [7:0] OP_DPD = 8'hB9;
    localparam logic [7:0] OP_RESUME = 8'hAB;
    localparam logic [7:0] OP_UDPD = 8'h79;

    // ==========================================================
    // Status byte shifted out on the data output
    localparam int ST_BUSY = 7;
    localparam int ST_PROT = 6;
    localparam int ST_LOCK = 5;
    localparam int ST_OVR = 4;
    localparam logic [7:0] ST_RESET = 8'h00;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_BUSY = 3'b001,
        M_DPD_ENT = 3'b010,
        M_DPD = 3'b011,
        M_RESUME = 3'b100,
        M_UDPD_ENT = 3'b101,
        M_UDPD = 3'b110,
        M_WAKE = 3'b111
    } sfl_mode_t;
endpackage

// [hw/sfl_stream_if.sv]
// Byte stream carrier between the link logic and its receive buffer.
// Valid and ready handshake; a word moves when both are high on a clock edge.
`timescale 1ns/1ns
interface sfl_stream_if #(parameter int W = 8) ();
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface

// [hw/sfl_fifo.sv]
// Receive buffer of the serial flash link: a shift-register FIFO.
// Assumes one clock domain; the head word always sits in entry 0.
`timescale 1ns/1ns
module sfl_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    sfl_stream_if.snk wr,
    output logic [W-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    generate
        if (DEPTH < 2 || W < 1) begin : g_bad
            $error("sfl_fifo: DEPTH must be at least 2 and W at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [DEPTH-1:0] vld;
    } sfl_fifo_st_t;

    sfl_fifo_st_t st;
    sfl_fifo_st_t next_st;

    // Ready only looks at the last slot, so a full buffer refuses even when
    // a pop happens in the same cycle; this keeps ready free of the sink.
    assign wr.ready = !st.vld[DEPTH-1];
    assign rd_data_out = st.mem[0];
    assign rd_valid_out = st.vld[0];

    always_comb begin
        logic placed;
        placed = 1'b0;
        next_st = st;
        if (st.vld[0] && rd_ready_in) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_st.mem[i] = st.mem[i+1];
                next_st.vld[i] = st.vld[i+1];
            end
            next_st.mem[DEPTH-1] = '0;
            next_st.vld[DEPTH-1] = 1'b0;
        end
        if (wr.valid && !st.vld[DEPTH-1]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!placed && !next_st.vld[i]) begin
                    next_st.mem[i] = wr.data;
                    next_st.vld[i] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// [tb/sfl_host_model.sv]
// Host controller model: master of the serial link, mode 0 framing.
// Assumes the link clock stays far below the system clock it is timed from.
`timescale 1ns/1ns
module sfl_host_model (
    input wire logic clk_in,
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    input wire logic so_in,
    input wire logic so_oe_in
);
    // ==========================================================
    // Link clock: 400 ns period, only inside frames
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end

    task automatic half();
        repeat (4) @(posedge clk_in);
        #1;
    endtask

    // ==========================================================
    // One frame: bytes out MSB first, status bytes captured back
    task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$],
                        output logic oe_any, output logic early);
        logic [7:0] b;
        rx = {};
        oe_any = 1'b0;
        early = 1'b0;
        @(posedge clk_in);
        #1;
        cs_n_out = 1'b0;
        foreach (tx[i]) begin
            for (int k = 7; k >= 0; k--) begin
                si_out = tx[i][k];
                half();
                if (i == 0 && k == 7) begin
                    early = so_in;
                end
                sck_out = 1'b1;
                half();
                b[k] = so_in;
                oe_any |= so_oe_in;
                sck_out = 1'b0;
            end
            rx.push_back(b);
        end
        half();
        cs_n_out = 1'b1;
        // Released data line shows a changed level, not the last bit
        si_out = ~si_out;
    endtask

    // Short select pulse that wakes ultra-deep power-down
    task automatic wake_pulse();
        @(posedge clk_in);
        #1;
        cs_n_out = 1'b0;
        half();
        cs_n_out = 1'b1;
    endtask
endmodule

// [tb/serial_flash_link_timing_tb.sv]
// Self-checking bench of the serial flash link block.
// Assumes the host model frames all traffic; erase-program, program and OTP ops use short parameters.
`timescale 1ns/1ns
module serial_flash_link_timing_tb;
    import sfl_pkg::*;
    localparam int EPC = 300;
    localparam int PC = 200;
    localparam int OTPC = 100;
    logic clk_in, arst_n_in, sck, cs_n, si, wp_n_in, so, so_oe;
    logic busy, prot, lock, dpd, udpd, ovr, rx_valid, rx_ready_in;
    logic [7:0] rx_data;
    logic [7:0] rxq[$];
    logic [7:0] r[$];
    logic oe, early;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;

    sfl_link #(.EP_CYCLES(EPC), .P_CYCLES(PC), .OTP_CYCLES(OTPC), .FIFO_DEPTH(8)) dut (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .sck_in(sck), .cs_n_in(cs_n),
        .si_in(si), .wp_n_in(wp_n_in), .so_out(so), .so_oe_out(so_oe),
        .busy_out(busy), .protect_out(prot), .lockdown_out(lock), .dpd_out(dpd),
        .udpd_out(udpd), .overrun_out(ovr), .rx_data_out(rx_data),
        .rx_valid_out(rx_valid), .rx_ready_in(rx_ready_in));

    sfl_host_model host (.clk_in(clk_in), .sck_out(sck), .cs_n_out(cs_n),
        .si_out(si), .so_in(so), .so_oe_in(so_oe));

    // ==========================================================
    // Clock, timeout and receive collector
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cyc++;
        if (rx_valid === 1'b1 && rx_ready_in === 1'b1) begin
            rxq.push_back(rx_data);
        end
        if (cyc == 60000) begin
            n_fail++;
            close_out();
        end
    end

    // ==========================================================
    // Compare and wait helpers
    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("FAIL %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return busy;
            1: return prot;
            2: return lock;
            3: return dpd;
            default: return udpd;
        endcase
    endfunction

    task automatic wait_lvl(input int s, input logic v, input int lim, output int n);
        n = 0;
        while (pick(s) !== v && n < lim) begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask

    task automatic status_read(input string name, input logic [7:0] exp);
        host.xfer('{8'h00, 8'h00}, r, oe, early);
        chk(name, exp, r[0]);
        chk(name, exp, r[1]);
        chk("first bit early", {7'h00, exp[7]}, {7'h00, early});
        chk("so_oe in frame", 8'h01, {7'h00, oe});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_protect();
        int n;
        wp_n_in = 1'b0;
        wait_lvl(1, 1'b1, WP_CYC + 10, n);
        chk_rng("protect on", 0, WP_CYC, n);
        status_read("status protected", 8'h40);
        wp_n_in = 1'b1;
        wait_lvl(1, 1'b0, WP_CYC + 10, n);
        chk_rng("protect off", 0, WP_CYC, n);
    endtask

    task automatic t_stream();
        rxq = {};
        host.xfer('{8'hA5, 8'h3C}, r, oe, early);
        repeat (4) @(posedge clk_in);
        #1;
        chk("so_oe after frame", 8'h00, {7'h00, so_oe});
        chk("rx count", 8'h02, 8'(rxq.size()));
        chk("rx byte0", 8'hA5, rxq[0]);
        chk("rx byte1", 8'h3C, rxq[1]);
    endtask

    task automatic t_op(input string name, input logic [7:0] op, input int cyc_max);
        int n;
        host.xfer('{op}, r, oe, early);
        wait_lvl(0, 1'b1, 10, n);
        chk_rng("busy start", 0, 6, n);
        wait_lvl(0, 1'b0, cyc_max + 20, n);
        chk_rng(name, cyc_max - 3, cyc_max + 1, n);
    endtask

    task automatic t_busy_refuse();
        int n;
        host.xfer('{OP_EP}, r, oe, early);
        wait_lvl(0, 1'b1, 10, n);
        host.xfer('{OP_LOCK}, r, oe, early);
        chk("status busy", 8'h80, r[0]);
        wait_lvl(0, 1'b0, EPC + 20, n);
        repeat (LOCK_CYC + 20) @(posedge clk_in);
        #1;
        chk("lock refused", 8'h00, {7'h00, lock});
    endtask

    task automatic t_lock();
        int n;
        host.xfer('{OP_LOCK}, r, oe, early);
        wait_lvl(2, 1'b1, LOCK_CYC + 20, n);
        chk_rng("lockdown time", 0, LOCK_CYC + 5, n);
        wait_lvl(0, 1'b0, 20, n);
        status_read("status locked", 8'h20);
    endtask

    task automatic t_power();
        int n;
        host.xfer('{OP_DPD}, r, oe, early);
        wait_lvl(3, 1'b1, EDPD_CYC + 20, n);
        chk_rng("dpd entry", 0, EDPD_CYC + 5, n);
        host.xfer('{8'h00}, r, oe, early);
        chk("so_oe in dpd", 8'h00, {7'h00, oe});
        host.xfer('{OP_RESUME}, r, oe, early);
        wait_lvl(3, 1'b0, RDPD_CYC + 20, n);
        wait_lvl(0, 1'b0, RDPD_CYC + 20, n);
        chk_rng("dpd resume", 0, RDPD_CYC + 5, n);
        host.xfer('{OP_UDPD}, r, oe, early);
        wait_lvl(4, 1'b1, EUDPD_CYC + 20, n);
        chk_rng("udpd entry", 0, EUDPD_CYC + 5, n);
        host.wake_pulse();
        wait_lvl(4, 1'b0, XUDPD_CYC + 20, n);
        wait_lvl(0, 1'b0, XUDPD_CYC + 20, n);
        chk_rng("udpd wake", 0, XUDPD_CYC + 5, n);
        status_read("status awake", 8'h20);
    endtask

    task automatic t_fifo();
        rxq = {};
        rx_ready_in = 1'b0;
        host.xfer('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                    8'h0A}, r, oe, early);
        repeat (4) @(posedge clk_in);
        #1;
        chk("overrun set", 8'h01, {7'h00, ovr});
        rx_ready_in = 1'b1;
        repeat (12) @(posedge clk_in);
        #1;
        chk("fifo count", 8'h08, 8'(rxq.size()));
        chk("fifo head", 8'h01, rxq[0]);
        chk("fifo last", 8'h08, rxq[7]);
        host.xfer('{8'h00}, r, oe, early);
        chk("overrun cleared", 8'h00, {7'h00, ovr});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        arst_n_in = 1'b0;
        wp_n_in = 1'b1;
        rx_ready_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        chk("reset outputs", 8'h00, {busy, prot, lock, dpd, udpd, ovr, rx_valid, so_oe});
        arst_n_in = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        status_read("status idle", 8'h00);
        t_stream();
        t_protect();
        t_op("transfer time", OP_XFR, XFR_CYC);
        t_op("compare time", OP_CMP, XFR_CYC);
        t_op("erase program time", OP_EP, EPC);
        t_op("program time", OP_PROG, PC);
        t_op("otp time", OP_OTP, OTPC);
        t_busy_refuse();
        t_lock();
        t_power();
        t_fifo();
        close_out();
    end
endmodule
